/* logic/adcso_buf_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface adcso_buf_if #(parameter int unsigned W = 10);
  logic [W-1:0] in_data;
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] out_data;
  logic         out_valid;
  logic         out_ready;
  modport buf_side (input in_data, input in_valid, output in_ready,
                    output out_data, output out_valid, input out_ready);
  modport user_side (output in_data, output in_valid, input in_ready,
                     input out_data, input out_valid, output out_ready);
endinterface : adcso_buf_if
`default_nettype wire

/* logic/adcso_core.sv */
// Overview of operation
// - Sampling and the pipeline sequencer both advance on the conversion clock.
// - While the power-down request is high the block stays in standby.
// - In standby the output word is held at DATA_RST (all zeros) and flagged not valid.
// - Entering standby voids every sample in flight in the pipeline.
// - With the format select high and no standby each word is two's complement.
// - With the format select low and no standby each word is offset binary.
// - The range pin decodes supply to 2.0 Vpp, ground to 1.5 Vpp, floating to 1.0 Vpp.
// - Each result leaves as a 10-bit parallel word.
// - While the receiver is ready, one word leaves per cycle, delayed from its sample by a fixed latency.
// - Offset binary midscale falls between 01 1111 1111 and 10 0000 0000.
`timescale 1ns/1ps
`default_nettype none
module adcso_core
  import adcso_pkg::*;
#(
  parameter int unsigned LATENCY = PIPE_LATENCY,
  parameter int unsigned W       = DATA_W
) (
  input  wire logic         clk_sys_i,
  input  wire logic         nrst_i,
  input  wire logic         power_down_request_i,
  input  wire logic         output_format_select_i,
  input  wire logic         range_at_supply_i,
  input  wire logic         range_at_ground_i,
  input  wire logic [W-1:0] sample_code_i,
  input  wire logic         rx_ready_i,
  output logic [W-1:0]      data_o,
  output logic              data_valid_o,
  output logic [1:0]        input_range_select_o,
  output logic              standby_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the first stage feeds only the second.
  logic         pwr_down_meta;
  logic         pwr_down;
  logic         fmt_meta;
  logic         fmt_sync;
  logic [1:0]   rng_meta;
  logic [1:0]   rng_sync;
  logic [W-1:0] code_meta;
  logic [W-1:0] code_sync;

  // Two stages only, so a standby request takes effect two edges after the pin moves.
  always_ff @(posedge clk_sys_i) begin
    pwr_down_meta <= power_down_request_i;
    pwr_down      <= pwr_down_meta;
  end

  always_ff @(posedge clk_sys_i) begin
    fmt_meta <= output_format_select_i;
    fmt_sync <= fmt_meta;
  end

  // Both pins low reads as a floating range pin.
  always_ff @(posedge clk_sys_i) begin
    rng_meta <= {range_at_supply_i, range_at_ground_i};
    rng_sync <= rng_meta;
  end

  // The code bus is not gray coded; it is only safe because its source moves on this clock.
  always_ff @(posedge clk_sys_i) begin
    code_meta <= sample_code_i;
    code_sync <= code_meta;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Coding.
  function automatic logic [W-1:0] encode(input logic [W-1:0] ob, input logic twos);
    encode = twos ? {~ob[W-1], ob[W-2:0]} : ob;
  endfunction : encode

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer.
  adcso_state_t state, next_state;
  logic [7:0]   fill;

  always_comb begin
    next_state = state;
    case (state)
      ADCSO_ST_STANDBY: if (!pwr_down) next_state = ADCSO_ST_REFILL;
      ADCSO_ST_REFILL: begin
        if (pwr_down) next_state = ADCSO_ST_STANDBY;
        else if (fill == 8'(LATENCY)) next_state = ADCSO_ST_RUN;
      end
      ADCSO_ST_RUN: if (pwr_down) next_state = ADCSO_ST_STANDBY;
      default: next_state = ADCSO_ST_STANDBY;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      state <= ADCSO_ST_STANDBY;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i || state != ADCSO_ST_REFILL) begin
      fill <= 8'h00;
    end else if (fill != 8'(LATENCY)) begin
      fill <= fill + 8'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Conversion pipeline: data shift plus a validity tag per stage.
  logic [W-1:0] pipe_d [LATENCY];
  logic         pipe_v [LATENCY];

  always_ff @(posedge clk_sys_i) begin
    pipe_d[0] <= code_sync;
    for (int i = 1; i < LATENCY; i++) begin
      pipe_d[i] <= pipe_d[i-1];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i || pwr_down) begin
      for (int i = 0; i < LATENCY; i++) begin
        pipe_v[i] <= 1'b0;
      end
    end else begin
      pipe_v[0] <= 1'b1;
      for (int i = 1; i < LATENCY; i++) begin
        pipe_v[i] <= pipe_v[i-1];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output buffer and registers.
  adcso_buf_if #(.W(W)) obuf ();
  logic out_ok;
  // Words that drain during refill are dropped, so refill always spans the latency.
  assign out_ok        = (state == ADCSO_ST_RUN) && !pwr_down && pipe_v[LATENCY-1];
  assign obuf.in_data  = encode(pipe_d[LATENCY-1], fmt_sync);
  assign obuf.in_valid = out_ok;
  assign obuf.out_ready = rx_ready_i;

  adcso_skid_buf #(.W(W)) u_buf (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i && !pwr_down),
    .bus       (obuf)
  );

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      data_o       <= DATA_RST;
      data_valid_o <= 1'b0;
    end else if (pwr_down) begin
      data_o       <= DATA_RST;
      data_valid_o <= 1'b0;
    end else begin
      data_o       <= obuf.out_data;
      data_valid_o <= obuf.out_valid && rx_ready_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      input_range_select_o <= RANGE_RST;
      standby_o            <= 1'b1;
    end else begin
      standby_o <= pwr_down;
      case (rng_sync)
        2'b10:   input_range_select_o <= ADCSO_RANGE_2V0;
        2'b01:   input_range_select_o <= ADCSO_RANGE_1V5;
        default: input_range_select_o <= ADCSO_RANGE_1V0;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  down_novalid_a : assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    pwr_down |=> !data_valid_o) else $error("valid word during standby");
  down_state_a : assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    pwr_down |=> state == ADCSO_ST_STANDBY) else $error("standby not held");
  refill_gap_a : assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    $fell(pwr_down) |-> !data_valid_o [*6]) else $error("valid inside refill");
  pipe_flush_a : assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    pwr_down |=> !pipe_v[LATENCY-1]) else $error("pipeline not flushed");
  twos_code_a : assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    obuf.in_valid && fmt_sync |-> obuf.in_data[W-1] != pipe_d[LATENCY-1][W-1])
    else $error("two's complement top bit wrong");
  offset_code_a : assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    obuf.in_valid && !fmt_sync |-> obuf.in_data == pipe_d[LATENCY-1])
    else $error("offset binary altered");
  range_dec_a : assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    rng_sync == 2'b01 |=> input_range_select_o == ADCSO_RANGE_1V5)
    else $error("range decode wrong");
  range_supply_a : assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    rng_sync == 2'b10 |=> input_range_select_o == ADCSO_RANGE_2V0)
    else $error("supply range decode wrong");
  range_float_a : assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    rng_sync == 2'b00 |=> input_range_select_o == ADCSO_RANGE_1V0)
    else $error("floating range decode wrong");

  // Nothing may enter the buffer before the pipeline has refilled with fresh samples.
  refill_hold_a : assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    state != ADCSO_ST_RUN |-> !obuf.in_valid) else $error("word pushed before run");
  refill_span_a : assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    state == ADCSO_ST_REFILL && next_state == ADCSO_ST_RUN |-> fill == 8'(LATENCY))
    else $error("refill ended early");

  // With the receiver ready this cycle and the last, an offered word must leave without a gap; a one-cycle stall still drops a word.
  run_stream_a : assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    state == ADCSO_ST_RUN && !pwr_down && rx_ready_i && $past(rx_ready_i) && obuf.out_valid
    |=> data_valid_o) else $error("stream gap in run");
  word_follow_a : assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    obuf.in_valid && rx_ready_i && !pwr_down |=> obuf.out_valid)
    else $error("pushed word not offered");

  // Cover points for steady streaming, wake-up, a full buffer, two's complement coding and a complete refill.
  run_cov : cover property (@(posedge clk_sys_i) state == ADCSO_ST_RUN && data_valid_o);
  wake_cov : cover property (@(posedge clk_sys_i) $fell(pwr_down));
  stall_cov : cover property (@(posedge clk_sys_i) !obuf.in_ready);
  twos_cov : cover property (@(posedge clk_sys_i) obuf.in_valid && fmt_sync);
  refill_cov : cover property (@(posedge clk_sys_i) state == ADCSO_ST_REFILL && fill == 8'(LATENCY));

endmodule : adcso_core
`default_nettype wire

/* logic/adcso_pkg.sv */
package adcso_pkg;

  localparam int unsigned DATA_W        = 10;
  localparam int unsigned PIPE_LATENCY  = 6;
  localparam logic [9:0]  MIDSCALE_LO   = 10'h1ff;
  localparam logic [9:0]  MIDSCALE_HI   = 10'h200;
  localparam logic [9:0]  DATA_RST      = 10'h000;
  localparam logic [1:0]  RANGE_RST     = 2'h0;

  // Full-scale span codes decoded from the three-level range pin.
  typedef enum logic [1:0] {
    ADCSO_RANGE_2V0 = 2'h0,
    ADCSO_RANGE_1V5 = 2'h1,
    ADCSO_RANGE_1V0 = 2'h2
  } adcso_range_t;

  typedef enum logic [2:0] {
    ADCSO_ST_STANDBY = 3'b001,
    ADCSO_ST_REFILL  = 3'b010,
    ADCSO_ST_RUN     = 3'b100
  } adcso_state_t;

endpackage : adcso_pkg

/* logic/adcso_skid_buf.sv */
`timescale 1ns/1ps
`default_nettype none
module adcso_skid_buf
  import adcso_pkg::*;
#(
  parameter int unsigned W = DATA_W
) (
  input  wire logic        clk_sys_i,
  input  wire logic        nrst_i,
  adcso_buf_if.buf_side    bus
);

  logic [W-1:0] mem [2];
  logic         wr_ptr;
  logic         rd_ptr;
  logic [1:0]   count;
  logic         push;
  logic         pop;

  // Two entries, but a full buffer refuses a push even in a cycle that pops, so a one-cycle receiver stall still loses a word.
  assign bus.in_ready  = (count != 2'h2);
  assign bus.out_valid = (count != 2'h0);
  assign bus.out_data  = mem[rd_ptr];
  assign push          = bus.in_valid && bus.in_ready;
  assign pop           = bus.out_valid && bus.out_ready;

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem[wr_ptr] <= bus.in_data;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

  no_overflow_a : assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    count <= 2'h2) else $error("buffer count above two");
  full_blocks_a : assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (count == 2'h2 && !bus.out_ready) |=> count == 2'h2) else $error("full buffer drained");

endmodule : adcso_skid_buf
`default_nettype wire

/* testbench/adcso_core_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module adcso_core_bench
  import adcso_pkg::*;
;
  logic              clk_sys_i;
  logic              nrst_i;
  logic              pdn;
  logic              fmt;
  logic              r_sup;
  logic              r_gnd;
  logic              stall;
  logic              ramp;
  logic [DATA_W-1:0] code;
  logic [DATA_W-1:0] data;
  logic [DATA_W-1:0] last;
  logic [1:0]        range;
  logic              valid;
  logic              ready;
  logic              standby;
  logic              got;
  int                err_total;
  int                check_count;
  int                cyc;
  adcso_core u_adcso_core (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .power_down_request_i(pdn), .output_format_select_i(fmt),
    .range_at_supply_i(r_sup), .range_at_ground_i(r_gnd), .sample_code_i(code),
    .rx_ready_i(ready), .data_o(data), .data_valid_o(valid),
    .input_range_select_o(range), .standby_o(standby));
  adcso_rx_model u_adcso_rx_model (.clk_sys_i(clk_sys_i), .stall_i(stall),
    .data_i(data), .valid_i(valid), .ready_o(ready), .last_o(last), .got_o(got));
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  always @(negedge clk_sys_i) begin
    if (ramp) begin
      code <= code + 10'h001;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop
  // A bounded wait, so a core that never answers shows up as a mismatch, not a hang.
  task automatic next_word;
    int i;
    for (i = 0; i < 40 && got !== 1'b1; i++) begin
      @(negedge clk_sys_i);
    end
    check("word arrives", {9'h000, got}, 10'h001);
  endtask : next_word
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_range;
    int i;
    for (i = 0; i < 3; i++) begin
      r_sup = (i == 0);
      r_gnd = (i == 1);
      repeat (5) @(negedge clk_sys_i);
      check("range", {8'h00, range}, 10'(i));
    end
    $display("range test done");
  endtask : test_range
  task automatic test_format(input logic f, input logic [9:0] c, input logic [9:0] exp);
    fmt = f;
    code = c;
    repeat (20) @(negedge clk_sys_i);
    next_word();
    check("coded word", last, exp);
    $display("format test done");
  endtask : test_format
  task automatic test_ramp_stall;
    logic [9:0] prev;
    int k;
    fmt = 1'b0;
    ramp = 1'b1;
    // The pipeline still holds the last fixed code, so let the ramp reach the output first.
    repeat (16) @(negedge clk_sys_i);
    next_word();
    prev = last;
    for (k = 0; k < 8; k++) begin
      @(negedge clk_sys_i);
      check("word each cycle", {9'h000, got}, 10'h001);
      check("ramp step", last, prev + 10'h001);
      prev = last;
    end
    stall = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    check("no word in stall", {9'h000, got}, 10'h000);
    stall = 1'b0;
    next_word();
    ramp = 1'b0;
    $display("ramp and stall test done");
  endtask : test_ramp_stall
  task automatic test_standby;
    int i;
    pdn = 1'b1;
    repeat (6) @(negedge clk_sys_i);
    check("standby", {9'h000, standby}, 10'h001);
    check("no word in standby", {9'h000, got}, 10'h000);
    pdn = 1'b0;
    for (i = 0; i < 10 && standby !== 1'b0; i++) begin
      @(negedge clk_sys_i);
    end
    for (i = 0; i < PIPE_LATENCY; i++) begin
      check("refill blank", {9'h000, got}, 10'h000);
      @(negedge clk_sys_i);
    end
    next_word();
    $display("standby test done");
  endtask : test_standby
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end
  initial begin
    {nrst_i, pdn, fmt, r_sup, r_gnd, stall, ramp} = 7'h00;
    code = 10'h000;
    err_total = 0;
    check_count = 0;
    cyc = 0;
    repeat (5) @(negedge clk_sys_i);
    check("reset standby", {9'h000, standby}, 10'h001);
    check("reset valid", {9'h000, valid}, 10'h000);
    check("reset range", {8'h00, range}, 10'h000);
    nrst_i = 1'b1;
    test_range();
    test_format(1'b0, MIDSCALE_LO, 10'h1ff);
    test_format(1'b0, MIDSCALE_HI, 10'h200);
    test_format(1'b1, 10'h000, 10'h200);
    test_format(1'b1, 10'h3ff, 10'h1ff);
    test_format(1'b1, 10'h1ff, 10'h3ff);
    test_ramp_stall();
    test_standby();
    report_and_stop();
  end
endmodule : adcso_core_bench
`default_nettype wire

/* testbench/adcso_rx_model.sv */
`timescale 1ns/1ps
`default_nettype none
module adcso_rx_model
  import adcso_pkg::*;
(
  input  wire logic              clk_sys_i,
  input  wire logic              stall_i,
  input  wire logic [DATA_W-1:0] data_i,
  input  wire logic              valid_i,
  output logic                   ready_o,
  output logic [DATA_W-1:0]      last_o,
  output logic                   got_o
);
  initial ready_o = 1'b0;
  // Ready moves on the falling edge so it never changes at the core's sampling edge.
  always @(negedge clk_sys_i) begin
    ready_o <= !stall_i;
  end
  // Words are taken on the rising edge of the conversion clock.
  always @(posedge clk_sys_i) begin
    got_o <= valid_i;
    if (valid_i) begin
      last_o <= data_i;
    end
  end
endmodule : adcso_rx_model
`default_nettype wire
